// file: hw/ifcr_cmp_if.sv
// Compare request and answer between the top and the compare unit
interface ifcr_cmp_if;
  ifcr_pkg::ifcr_cmp_e   kind;
  ifcr_pkg::ifcr_word_t  a;
  ifcr_pkg::ifcr_word_t  b;
  logic                  mode64;
  logic                  so;
  ifcr_pkg::ifcr_field_t result;
  modport requester (output kind, a, b, mode64, so, input result);
  modport unit      (input kind, a, b, mode64, so, output result);
endinterface : ifcr_cmp_if

// file: hw/ifcr_compare.sv
// Compare unit: builds a four-bit condition field from two operands
`include "ifcr_consts.svh"
module ifcr_compare (
  // Request and answer
  ifcr_cmp_if.unit c
);
  logic [63:0] a_w;
  logic [63:0] b_w;
  logic        lt;
  logic        gt;
  logic        eq;
  logic        un;
  logic        a_nan;
  logic        b_nan;
  logic [63:0] a_key;
  logic [63:0] b_key;

  // Map a double onto an unsigned key that orders like the number
  function automatic logic [63:0] ifcr_fkey(input logic [63:0] v);
    logic [63:0] k;
    k = v[63] ? ~v : {1'b1, v[62:0]};
    if (v[62:0] == 63'h0) begin
      k = 64'h8000_0000_0000_0000;
    end
    return k;
  endfunction : ifcr_fkey

  function automatic logic ifcr_isnan(input logic [63:0] v);
    return (v[62:52] == `IFCR_DP_EMAX) && (v[51:0] != 52'h0);
  endfunction : ifcr_isnan

  always_comb begin
    // Word mode compares the low 32 bits, sign extended or zero extended
    a_w = c.a;
    b_w = c.b;
    if (!c.mode64) begin
      a_w = (c.kind == ifcr_pkg::IFCR_CMP_SIGNED) ?
            {{32{c.a[31]}}, c.a[31:0]} : {32'h0, c.a[31:0]};
      b_w = (c.kind == ifcr_pkg::IFCR_CMP_SIGNED) ?
            {{32{c.b[31]}}, c.b[31:0]} : {32'h0, c.b[31:0]};
    end
    a_nan = ifcr_isnan(c.a);
    b_nan = ifcr_isnan(c.b);
    a_key = ifcr_fkey(c.a);
    b_key = ifcr_fkey(c.b);
    lt = 1'b0;
    gt = 1'b0;
    eq = 1'b0;
    un = c.so;
    unique case (c.kind)
      ifcr_pkg::IFCR_CMP_SIGNED: begin
        lt = $signed(a_w) < $signed(b_w);
        gt = $signed(a_w) > $signed(b_w);
        eq = a_w == b_w;
      end
      ifcr_pkg::IFCR_CMP_UNSIGNED: begin
        lt = a_w < b_w;
        gt = a_w > b_w;
        eq = a_w == b_w;
      end
      ifcr_pkg::IFCR_CMP_FLOAT: begin
        un = a_nan | b_nan;
        lt = !un && (a_key < b_key);
        gt = !un && (a_key > b_key);
        eq = !un && (a_key == b_key);
      end
      ifcr_pkg::IFCR_CMP_NONE: begin
        un = 1'b0;
      end
      default: begin
        un = 1'b0;
      end
    endcase
    c.result = {un, eq, gt, lt};
  end
endmodule : ifcr_compare

// file: hw/ifcr_consts.svh
// Constants of the integer, float and condition register block
`ifndef IFCR_CONSTS_SVH
`define IFCR_CONSTS_SVH
`define IFCR_NREGS       32
`define IFCR_IDX_W       5
`define IFCR_XLEN        64
`define IFCR_FLEN        64
`define IFCR_CR_W        32
`define IFCR_FIELD_W     4
`define IFCR_NFIELDS     8
`define IFCR_FLD_IDX_W   3
`define IFCR_CR_RESET    32'h0000_0000
`define IFCR_LT_BIT      0
`define IFCR_GT_BIT      1
`define IFCR_EQ_BIT      2
`define IFCR_SO_BIT      3
`define IFCR_REC_FIELD   3'h0
`define IFCR_FREC_FIELD  3'h1
`define IFCR_SP_BIAS     11'h380
`define IFCR_DP_EMAX     11'h7ff
`endif

// file: hw/ifcr_pkg.sv
// Types of the integer, float and condition register block
package ifcr_pkg;
  typedef logic [63:0] ifcr_word_t;
  typedef logic [3:0]  ifcr_field_t;
  typedef logic [31:0] ifcr_cr_t;
  // Condition register write operation
  typedef enum logic [7:0] {
    IFCR_OP_NONE  = 8'h01,
    IFCR_OP_MTCRF = 8'h02,
    IFCR_OP_XFLD  = 8'h04,
    IFCR_OP_FFLD  = 8'h08,
    IFCR_OP_LOGIC = 8'h10,
    IFCR_OP_IREC  = 8'h20,
    IFCR_OP_FREC  = 8'h40,
    IFCR_OP_CMP   = 8'h80
  } ifcr_crop_e;
  // Compare variant
  typedef enum logic [3:0] {
    IFCR_CMP_SIGNED   = 4'h1,
    IFCR_CMP_UNSIGNED = 4'h2,
    IFCR_CMP_FLOAT    = 4'h4,
    IFCR_CMP_NONE     = 4'h8
  } ifcr_cmp_e;
  // Float register write source
  typedef enum logic [3:0] {
    IFCR_FW_NONE   = 4'h1,
    IFCR_FW_DOUBLE = 4'h2,
    IFCR_FW_SINGLE = 4'h4,
    IFCR_FW_ARITH  = 4'h8
  } ifcr_fw_e;
endpackage : ifcr_pkg

// file: hw/ifcr_regs.sv
// Integer, float and condition register set with condition updates
//
// Overview of operation
// - 32 integer registers, 64 or 32 bits
// - 32 float registers, always 64 bits
// - Float values read as double precision
// - Float arithmetic reads and writes float registers
// - Double loads and stores pass unchanged
// - Single loads widen to double format
// - Single stores narrow double to single
// - Arithmetic result rounded by execution unit
// - Condition word has eight four-bit fields
// - Field move updates only selected fields
// - Integer exception field copies into condition
// - Float status field copies into condition
// - Bitwise condition logic and single bit tests
// - Recorded integer sets field zero
// - Negative, positive, zero, summary overflow bits
// - Undefined result clears low three bits to zero
// - Word multiply high, divide undefined 64-bit
// - Recorded float copies status into field one
// - Compare sets bit two on equality
// - Compare bit three summary or unordered
`include "ifcr_consts.svh"
module ifcr_regs (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Mode
  input  wire logic                 mode64,
  // Integer read ports
  input  wire logic [4:0]           int_ra_idx,
  input  wire logic [4:0]           int_rb_idx,
  output      logic [63:0]          int_ra_data,
  output      logic [63:0]          int_rb_data,
  // Integer write port
  input  wire logic                 int_we,
  input  wire logic [4:0]           int_w_idx,
  input  wire logic [63:0]          int_w_data,
  // Float read ports
  input  wire logic [4:0]           flt_ra_idx,
  input  wire logic [4:0]           flt_rb_idx,
  output      logic [63:0]          flt_ra_data,
  output      logic [63:0]          flt_rb_data,
  // Float write port
  input  wire ifcr_pkg::ifcr_fw_e   flt_w_kind,
  input  wire logic [4:0]           flt_w_idx,
  input  wire logic [63:0]          flt_w_data,
  // Float store data
  input  wire logic [4:0]           flt_st_idx,
  output      logic [63:0]          flt_st_double,
  output      logic [31:0]          flt_st_single,
  // Condition operation
  input  wire ifcr_pkg::ifcr_crop_e cr_op,
  input  wire logic [2:0]           cr_dst_field,
  input  wire logic [7:0]           cr_field_mask,
  input  wire logic [3:0]           cr_src_nibble,
  input  wire logic [4:0]           cr_bit_a,
  input  wire logic [4:0]           cr_bit_b,
  input  wire logic [4:0]           cr_bit_d,
  input  wire logic [3:0]           cr_logic_tt,
  input  wire ifcr_pkg::ifcr_cmp_e  cmp_kind,
  input  wire logic                 cmp_use_imm,
  input  wire logic [63:0]          cmp_imm,
  input  wire logic                 summary_ovf,
  input  wire logic [3:0]           float_status_top,
  input  wire logic                 rec_undefined,
  // Condition state
  input  wire logic [4:0]           cr_test_bit,
  output      logic                 cr_test_value,
  output      logic [31:0]          condition_flags_register
);
  typedef struct packed {
    logic [31:0][63:0] integer_register_file;
    logic [31:0][63:0] float_register_file;
    logic [31:0]       cr;
    logic [63:0]       st_d;
    logic [31:0]       st_s;
  } ifcr_state_s;

  ifcr_state_s s_q;
  ifcr_state_s s_d;
  logic [63:0] xlen_mask;
  logic [63:0] rec_val;
  logic [3:0]  rec_fld;
  logic [3:0]  cmp_fld;
  logic        lbit;

  ifcr_cmp_if cmp ();

  ////////////////////////////////////////////////////////////////////////////
  // Format conversion

  // Single to double: exponent rebias, fraction padded; denormals normalized
  function automatic logic [63:0] ifcr_widen(input logic [31:0] v);
    logic [63:0] r;
    logic [22:0] f;
    logic [10:0] e;
    integer      i;
    logic        done;
    r = {v[31], 63'h0};
    f = v[22:0];
    e = 11'h0;
    done = 1'b0;
    if (v[30:23] == 8'hff) begin
      r = {v[31], `IFCR_DP_EMAX, v[22:0], 29'h0};
    end else if (v[30:23] != 8'h00) begin
      r = {v[31], 11'(v[30:23]) + `IFCR_SP_BIAS, v[22:0], 29'h0};
    end else if (f != 23'h0) begin
      e = `IFCR_SP_BIAS + 11'h1;
      for (i = 0; i < 23; i++) begin
        if (!done) begin
          e = e - 11'h1;
          done = f[22];
          f = {f[21:0], 1'b0};
        end
      end
      r = {v[31], e, f, 29'h0};
    end
    return r;
  endfunction : ifcr_widen

  // Double to single by bit selection, shifted for denormals, zero below; input assumed single representable
  function automatic logic [31:0] ifcr_narrow(input logic [63:0] v);
    logic [31:0] r;
    logic [10:0] sh;
    logic [23:0] m;
    if (v[62:52] > `IFCR_SP_BIAS || v[62:52] == `IFCR_DP_EMAX) begin
      r = {v[63], v[62], v[58:52], v[51:29]};
    end else if (v[62:52] > `IFCR_SP_BIAS - 11'd23) begin
      sh = `IFCR_SP_BIAS + 11'h1 - v[62:52];
      m = {1'b1, v[51:29]} >> sh;
      r = {v[63], 8'h00, m[22:0]};
    end else begin
      r = {v[63], 31'h0};
    end
    return r;
  endfunction : ifcr_narrow

  ////////////////////////////////////////////////////////////////////////////
  // Compare unit

  assign cmp.kind   = cmp_kind;
  assign cmp.a      = (cmp_kind == ifcr_pkg::IFCR_CMP_FLOAT) ?
                      s_q.float_register_file[flt_ra_idx] : (s_q.integer_register_file[int_ra_idx] & xlen_mask);
  assign cmp.b      = (cmp_kind == ifcr_pkg::IFCR_CMP_FLOAT) ?
                      s_q.float_register_file[flt_rb_idx] :
                      (cmp_use_imm ? cmp_imm : s_q.integer_register_file[int_rb_idx] & xlen_mask);
  assign cmp.mode64 = mode64;
  assign cmp.so     = summary_ovf;
  assign cmp_fld    = cmp.result;

  ifcr_compare u_cmp (
    .c (cmp.unit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // upper half unused in 32-bit mode
  assign xlen_mask = mode64 ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;

  always_comb begin
    s_d = s_q;
    rec_val = mode64 ? int_w_data : {{32{int_w_data[31]}}, int_w_data[31:0]};
    // signed compare of result with zero
    rec_fld = {summary_ovf, rec_val == 64'h0,
               !rec_val[63] && rec_val != 64'h0, rec_val[63]};
    // undefined result shows zeroes in low bits
    // caller raises rec_undefined for word forms in 64-bit mode
    if (rec_undefined) begin
      rec_fld[2:0] = 3'h0;
    end
    lbit = cr_logic_tt[{s_q.cr[cr_bit_a], s_q.cr[cr_bit_b]}];

    if (int_we) begin
      s_d.integer_register_file[int_w_idx] = int_w_data & xlen_mask;
    end

    unique case (flt_w_kind)
      ifcr_pkg::IFCR_FW_NONE: begin
      end
      ifcr_pkg::IFCR_FW_DOUBLE: begin
        s_d.float_register_file[flt_w_idx] = flt_w_data;
      end
      ifcr_pkg::IFCR_FW_SINGLE: begin
        s_d.float_register_file[flt_w_idx] = ifcr_widen(flt_w_data[31:0]);
      end
      // rounded result arrives in final form
      ifcr_pkg::IFCR_FW_ARITH: begin
        s_d.float_register_file[flt_w_idx] = flt_w_data;
      end
      default: begin
      end
    endcase

    unique case (cr_op)
      ifcr_pkg::IFCR_OP_NONE: begin
      end
      ifcr_pkg::IFCR_OP_MTCRF: begin
        for (int i = 0; i < `IFCR_NFIELDS; i++) begin
          if (cr_field_mask[i]) begin
            s_d.cr[i*4 +: 4] = s_q.integer_register_file[int_ra_idx][i*4 +: 4];
          end
        end
      end
      ifcr_pkg::IFCR_OP_XFLD, ifcr_pkg::IFCR_OP_FFLD: begin
        s_d.cr[cr_dst_field*4 +: 4] = cr_src_nibble;
      end
      ifcr_pkg::IFCR_OP_LOGIC: begin
        s_d.cr[cr_bit_d] = lbit;
      end
      ifcr_pkg::IFCR_OP_IREC: begin
        s_d.cr[`IFCR_REC_FIELD*4 +: 4] = rec_fld;
      end
      ifcr_pkg::IFCR_OP_FREC: begin
        s_d.cr[`IFCR_FREC_FIELD*4 +: 4] = float_status_top;
      end
      ifcr_pkg::IFCR_OP_CMP: begin
        s_d.cr[cr_dst_field*4 +: 4] = cmp_fld;
      end
      default: begin
      end
    endcase

    s_d.st_d = s_q.float_register_file[flt_st_idx];
    s_d.st_s = ifcr_narrow(s_q.float_register_file[flt_st_idx]);

    if (rst) begin
      s_d.cr   = `IFCR_CR_RESET;
      s_d.st_d = 64'h0;
      s_d.st_s = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // float operands read raw as doubles
  assign int_ra_data   = s_q.integer_register_file[int_ra_idx] & xlen_mask;
  assign int_rb_data   = s_q.integer_register_file[int_rb_idx] & xlen_mask;
  assign flt_ra_data   = s_q.float_register_file[flt_ra_idx];
  assign flt_rb_data   = s_q.float_register_file[flt_rb_idx];
  assign flt_st_double = s_q.st_d;
  assign flt_st_single = s_q.st_s;
  // fields stored as nibbles, field 0 at bits 3..0
  assign cr_test_value = s_q.cr[cr_test_bit];
  assign condition_flags_register = s_q.cr;
endmodule : ifcr_regs

// file: tb/ifcr_mem_model.sv
// Memory side of the load/store unit: keeps the last store data
module ifcr_mem_model (
  // Clock
  input  wire logic        clk,
  // Store data from the register block
  input  wire logic [63:0] st_double,
  input  wire logic [31:0] st_single,
  // Stored words
  output      logic [63:0] mem_dw,
  output      logic [31:0] mem_w
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    mem_dw <= st_double;
    mem_w  <= st_single;
  end
endmodule : ifcr_mem_model

// file: tb/ifcr_regs_props.sv
// Port assertions of the register block
module ifcr_regs_props (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // Register writes and reads
  input wire logic                 mode64,
  input wire logic                 int_we,
  input wire logic [4:0]           int_w_idx,
  input wire logic [63:0]          int_w_data,
  input wire logic [4:0]           int_ra_idx,
  input wire logic [4:0]           int_rb_idx,
  input wire logic [63:0]          int_ra_data,
  input wire ifcr_pkg::ifcr_fw_e   flt_w_kind,
  input wire logic [4:0]           flt_w_idx,
  input wire logic [63:0]          flt_w_data,
  input wire logic [4:0]           flt_ra_idx,
  input wire logic [63:0]          flt_ra_data,
  // Condition operation
  input wire ifcr_pkg::ifcr_crop_e cr_op,
  input wire logic [2:0]           cr_dst_field,
  input wire logic [7:0]           cr_field_mask,
  input wire ifcr_pkg::ifcr_cmp_e  cmp_kind,
  input wire logic                 cmp_use_imm,
  input wire logic                 summary_ovf,
  input wire logic [3:0]           float_status_top,
  input wire logic                 rec_undefined,
  input wire logic [4:0]           cr_test_bit,
  input wire logic                 cr_test_value,
  input wire logic [31:0]          condition_flags_register
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_int_wr;
    int_we && mode64 ##1 mode64 && int_ra_idx == $past(int_w_idx);
  endsequence
  sequence s_dbl_wr;
    flt_w_kind == ifcr_pkg::IFCR_FW_DOUBLE ##1 flt_ra_idx == $past(flt_w_idx);
  endsequence
  a_int_wr_read: assert property (
    s_int_wr |-> int_ra_data == $past(int_w_data)) else $error("int read");
  a_dbl_wr_raw: assert property (
    s_dbl_wr |-> flt_ra_data == $past(flt_w_data)) else $error("dbl read");
  a_irec_onehot: assert property (
    cr_op == ifcr_pkg::IFCR_OP_IREC && !rec_undefined
    |=> $onehot(condition_flags_register[2:0])) else $error("irec sign");
  a_irec_so: assert property (
    cr_op == ifcr_pkg::IFCR_OP_IREC
    |=> condition_flags_register[3] == $past(summary_ovf)) else $error("so");
  a_irec_undef: assert property (
    cr_op == ifcr_pkg::IFCR_OP_IREC && rec_undefined
    |=> condition_flags_register[2:0] == 3'h0) else $error("undef");
  a_frec_copy: assert property (
    cr_op == ifcr_pkg::IFCR_OP_FREC
    |=> condition_flags_register[7:4] == $past(float_status_top))
    else $error("frec");
  a_mtcrf_only: assert property (
    cr_op == ifcr_pkg::IFCR_OP_MTCRF && cr_field_mask == 8'h82
    |=> condition_flags_register[31:28] == $past(int_ra_data[31:28])
    && condition_flags_register[27:8] == $past(condition_flags_register[27:8]))
    else $error("mtcrf");
  a_cmp_same: assert property (
    cr_op == ifcr_pkg::IFCR_OP_CMP
    && (cmp_kind == ifcr_pkg::IFCR_CMP_SIGNED
    || cmp_kind == ifcr_pkg::IFCR_CMP_UNSIGNED)
    && !cmp_use_imm && int_ra_idx == int_rb_idx
    |=> condition_flags_register[{$past(cr_dst_field), 2'h0} +: 4]
    == {$past(summary_ovf), 3'h4}) else $error("cmp equal");
  a_test_bit: assert property (
    cr_test_value == condition_flags_register[cr_test_bit]) else $error("bit");
endmodule : ifcr_regs_props

// file: tb/integer_float_condition_regs_tb_top.sv
// Self-checking bench of the register block
module integer_float_condition_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 mode64 = 1'b1;
  logic                 int_we, rec_undefined, summary_ovf, cmp_use_imm;
  logic                 cr_test_value;
  logic [4:0]           int_ra_idx, int_rb_idx, int_w_idx, flt_ra_idx;
  logic [4:0]           flt_rb_idx, flt_w_idx, flt_st_idx, cr_test_bit;
  logic [4:0]           cr_bit_a, cr_bit_b, cr_bit_d;
  logic [63:0]          int_ra_data, int_rb_data, int_w_data, flt_ra_data;
  logic [63:0]          flt_rb_data, flt_w_data, flt_st_double, cmp_imm;
  logic [63:0]          mem_dw;
  logic [31:0]          flt_st_single, condition_flags_register, mem_w, exp_cr;
  logic [7:0]           cr_field_mask;
  logic [3:0]           cr_src_nibble, cr_logic_tt, float_status_top;
  logic [2:0]           cr_dst_field;
  ifcr_pkg::ifcr_fw_e   flt_w_kind;
  ifcr_pkg::ifcr_crop_e cr_op;
  ifcr_pkg::ifcr_cmp_e  cmp_kind;
  int                   n_mismatch = 0;
  int                   compares = 0;
  always #10 clk = ~clk;
  ifcr_regs dut (.clk, .rst, .mode64, .int_ra_idx, .int_rb_idx, .int_ra_data,
    .int_rb_data, .int_we, .int_w_idx, .int_w_data, .flt_ra_idx, .flt_rb_idx,
    .flt_ra_data, .flt_rb_data, .flt_w_kind, .flt_w_idx, .flt_w_data,
    .flt_st_idx, .flt_st_double, .flt_st_single, .cr_op, .cr_dst_field,
    .cr_field_mask, .cr_src_nibble, .cr_bit_a, .cr_bit_b, .cr_bit_d,
    .cr_logic_tt, .cmp_kind, .cmp_use_imm, .cmp_imm, .summary_ovf,
    .float_status_top, .rec_undefined, .cr_test_bit, .cr_test_value,
    .condition_flags_register);
  ifcr_mem_model mem (.clk(clk), .st_double(flt_st_double),
    .st_single(flt_st_single), .mem_dw(mem_dw), .mem_w(mem_w));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input logic we, input ifcr_pkg::ifcr_fw_e fk,
                      input ifcr_pkg::ifcr_crop_e op);
    int_we = we;
    flt_w_kind = fk;
    cr_op = op;
    @(posedge clk);
    @(negedge clk);
  endtask : step
  task automatic cop(input ifcr_pkg::ifcr_crop_e op);
    step(1'b0, ifcr_pkg::IFCR_FW_NONE, op);
  endtask : cop
  task automatic iw(input logic [4:0] i, input logic [63:0] d,
                    input ifcr_pkg::ifcr_crop_e op);
    int_w_idx = i;
    int_w_data = d;
    step(1'b1, ifcr_pkg::IFCR_FW_NONE, op);
  endtask : iw
  task automatic fw(input logic [4:0] i, input logic [63:0] d,
                    input ifcr_pkg::ifcr_fw_e k);
    flt_w_idx = i;
    flt_w_data = d;
    step(1'b0, k, ifcr_pkg::IFCR_OP_NONE);
  endtask : fw
  task automatic cmpc(input ifcr_pkg::ifcr_cmp_e k, input logic [4:0] ra, rb,
                      input logic imm_on, so, input logic [3:0] nib);
    cmp_kind = k;
    {int_ra_idx, flt_ra_idx, int_rb_idx, flt_rb_idx} = {ra, ra, rb, rb};
    cmp_use_imm = imm_on;
    summary_ovf = so;
    cop(ifcr_pkg::IFCR_OP_CMP);
    exp_cr[15:12] = nib;
    chk(condition_flags_register, exp_cr);
  endtask : cmpc
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_int;
    int_ra_idx = 5'h03;
    iw(5'h03, 64'hffff_ffff_ffff_fffb, ifcr_pkg::IFCR_OP_IREC);
    exp_cr[3:0] = 4'h1;
    chk(condition_flags_register, exp_cr);
    chk(int_ra_data, 64'hffff_ffff_ffff_fffb);
    summary_ovf = 1'b1;
    iw(5'h03, 64'h7, ifcr_pkg::IFCR_OP_IREC);
    chk(condition_flags_register[3:0], 4'ha);
    rec_undefined = 1'b1;
    iw(5'h03, 64'h0, ifcr_pkg::IFCR_OP_IREC);
    chk(condition_flags_register[3:0], 4'h8);
    {rec_undefined, summary_ovf, mode64} = 3'h0;
    iw(5'h03, 64'h1_8000_0000, ifcr_pkg::IFCR_OP_IREC);
    chk(condition_flags_register[3:0], 4'h1);
    chk(int_ra_data, 64'h8000_0000);
    mode64 = 1'b1;
  endtask : t_int
  task automatic t_flt;
    {flt_ra_idx, flt_rb_idx, flt_st_idx} = {5'h01, 5'h02, 5'h02};
    fw(5'h01, 64'hc00f_0000_1234_5678, ifcr_pkg::IFCR_FW_DOUBLE);
    chk(flt_ra_data, 64'hc00f_0000_1234_5678);
    fw(5'h02, 64'hdead_beef_c020_0000, ifcr_pkg::IFCR_FW_SINGLE);
    chk(flt_rb_data, 64'hc004_0000_0000_0000);
    fw(5'h01, 64'h4009_21fb_5444_2d18, ifcr_pkg::IFCR_FW_ARITH);
    chk(flt_ra_data, 64'h4009_21fb_5444_2d18);
    chk(flt_st_single, 32'hc020_0000);
    chk(flt_st_double, 64'hc004_0000_0000_0000);
    cop(ifcr_pkg::IFCR_OP_NONE);
    chk(mem_w, 32'hc020_0000);
    chk(mem_dw, 64'hc004_0000_0000_0000);
  endtask : t_flt
  task automatic t_fields;
    float_status_top = 4'ha;
    cop(ifcr_pkg::IFCR_OP_FREC);
    exp_cr[7:4] = 4'ha;
    chk(condition_flags_register, exp_cr);
    {cr_dst_field, cr_src_nibble} = {3'h5, 4'h9};
    cop(ifcr_pkg::IFCR_OP_XFLD);
    exp_cr[23:20] = 4'h9;
    chk(condition_flags_register, exp_cr);
    {cr_dst_field, cr_src_nibble} = {3'h6, 4'h6};
    cop(ifcr_pkg::IFCR_OP_FFLD);
    exp_cr[27:24] = 4'h6;
    chk(condition_flags_register, exp_cr);
    {int_ra_idx, cr_field_mask} = {5'h05, 8'h82};
    iw(5'h05, 64'hfedc_ba98_7654_3210, ifcr_pkg::IFCR_OP_NONE);
    cop(ifcr_pkg::IFCR_OP_MTCRF);
    {exp_cr[31:28], exp_cr[7:4]} = 8'h71;
    chk(condition_flags_register, exp_cr);
  endtask : t_fields
  task automatic t_logic;
    cr_bit_d = 5'h0c;
    for (int i = 0; i < 16; i++) begin
      cr_logic_tt = 4'(i);
      cr_bit_a = i[1] ? 5'h05 : 5'h04;
      cr_bit_b = i[2] ? 5'h1c : 5'h1f;
      cop(ifcr_pkg::IFCR_OP_LOGIC);
      exp_cr[12] = cr_logic_tt[{exp_cr[cr_bit_a], exp_cr[cr_bit_b]}];
      chk(condition_flags_register, exp_cr);
    end
    for (int i = 0; i < 32; i++) begin
      cr_test_bit = 5'(i);
      cop(ifcr_pkg::IFCR_OP_NONE);
      chk(cr_test_value, exp_cr[i]);
    end
  endtask : t_logic
  task automatic t_cmp;
    iw(5'h06, 64'hffff_ffff_ffff_ffff, ifcr_pkg::IFCR_OP_NONE);
    iw(5'h07, 64'h1, ifcr_pkg::IFCR_OP_NONE);
    fw(5'h08, 64'h3ff0_0000_0000_0000, ifcr_pkg::IFCR_FW_DOUBLE);
    fw(5'h09, 64'h4000_0000_0000_0000, ifcr_pkg::IFCR_FW_DOUBLE);
    fw(5'h0a, 64'h7ff8_0000_0000_0000, ifcr_pkg::IFCR_FW_DOUBLE);
    fw(5'h0b, 64'h8000_0000_0000_0000, ifcr_pkg::IFCR_FW_DOUBLE);
    fw(5'h0c, 64'h0, ifcr_pkg::IFCR_FW_DOUBLE);
    cr_dst_field = 3'h3;
    cmpc(ifcr_pkg::IFCR_CMP_SIGNED, 5'h06, 5'h07, 1'b0, 1'b0, 4'h1);
    chk(int_rb_data, 64'h1);
    cmpc(ifcr_pkg::IFCR_CMP_UNSIGNED, 5'h06, 5'h07, 1'b0, 1'b0, 4'h2);
    cmpc(ifcr_pkg::IFCR_CMP_SIGNED, 5'h06, 5'h07, 1'b1, 1'b1, 4'hc);
    cmpc(ifcr_pkg::IFCR_CMP_SIGNED, 5'h07, 5'h07, 1'b0, 1'b0, 4'h4);
    cmpc(ifcr_pkg::IFCR_CMP_FLOAT, 5'h08, 5'h09, 1'b0, 1'b1, 4'h1);
    cmpc(ifcr_pkg::IFCR_CMP_FLOAT, 5'h0a, 5'h08, 1'b0, 1'b0, 4'h8);
    cmpc(ifcr_pkg::IFCR_CMP_FLOAT, 5'h0b, 5'h0c, 1'b0, 1'b0, 4'h4);
    // Word mode: low 32 bits sign or zero extended before the compare
    mode64 = 1'b0;
    cmpc(ifcr_pkg::IFCR_CMP_SIGNED, 5'h06, 5'h07, 1'b0, 1'b0, 4'h1);
    cmpc(ifcr_pkg::IFCR_CMP_UNSIGNED, 5'h06, 5'h07, 1'b1, 1'b0, 4'h4);
    mode64 = 1'b1;
  endtask : t_cmp
  task automatic t_reset;
    rst = 1'b1;
    cop(ifcr_pkg::IFCR_OP_NONE);
    chk(condition_flags_register, 32'h0);
    chk(flt_st_single, 32'h0);
    chk(flt_st_double, 64'h0);
    rst = 1'b0;
    iw(5'h06, 64'h5, ifcr_pkg::IFCR_OP_IREC);
    chk(condition_flags_register, 32'h2);
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {int_we, rec_undefined, summary_ovf, cmp_use_imm, exp_cr} = '0;
    {int_ra_idx, int_rb_idx, int_w_idx, flt_ra_idx, flt_rb_idx} = '0;
    {flt_w_idx, flt_st_idx, cr_bit_a, cr_bit_b, cr_bit_d, cr_test_bit} = '0;
    {int_w_data, flt_w_data, cr_dst_field, cr_field_mask} = '0;
    {cr_src_nibble, cr_logic_tt, float_status_top} = '0;
    cmp_imm = '1;
    flt_w_kind = ifcr_pkg::IFCR_FW_NONE;
    cr_op = ifcr_pkg::IFCR_OP_NONE;
    cmp_kind = ifcr_pkg::IFCR_CMP_NONE;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(condition_flags_register, 32'h0);
    t_int();
    t_flt();
    t_fields();
    t_logic();
    t_cmp();
    t_reset();
    close_out();
  end
  initial begin
    #50000;
    n_mismatch++;
    close_out();
  end
endmodule : integer_float_condition_regs_tb_top
bind ifcr_regs ifcr_regs_props props (.clk, .rst, .mode64, .int_we,
  .int_w_idx, .int_w_data, .int_ra_idx, .int_rb_idx, .int_ra_data,
  .flt_w_kind, .flt_w_idx, .flt_w_data, .flt_ra_idx, .flt_ra_data, .cr_op,
  .cr_dst_field, .cr_field_mask, .cmp_kind, .cmp_use_imm, .summary_ovf,
  .float_status_top, .rec_undefined, .cr_test_bit, .cr_test_value,
  .condition_flags_register);
